// File: ssi_pkg.sv
// Package for the synchronisation status indicator: register map, fields,
// reset values, timing constants and the single state struct.
// Assumes a 100 MHz hclk and an AHB-Lite bus with 32-bit data.
package ssi_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FLASH_HALF_MS = 500;
	localparam int unsigned FLASH_HALF_CYC_DEF = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int unsigned ACT_HOLD_MS = 20;
	localparam int unsigned ACT_HOLD_CYC_DEF = CLK_HZ / 1000 * ACT_HOLD_MS;
	localparam int unsigned OUTAGE_DAYS = 3;
	localparam logic [31:0] OUTAGE_MAX_S = 32'(OUTAGE_DAYS * 24 * 3600);

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SSI_STATE_OFS = 8'h00;
	localparam logic [7:0] SSI_THRESH_OFS = 8'h04;
	localparam logic [7:0] SSI_CMD_OFS = 8'h08;
	localparam logic [7:0] SSI_STATUS_OFS = 8'h0c;
	localparam logic [7:0] SSI_UTC_OFS = 8'h10;
	localparam logic [7:0] SSI_DST_OFS = 8'h14;
	localparam logic [7:0] SSI_TIMERS_OFS = 8'h18;
	localparam logic [7:0] SSI_TIME_OFS = 8'h1c;
	localparam logic [7:0] SSI_OUTAGE_OFS = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CMD_RESTART_BIT = 0;
	localparam int CMD_DEFAULTS_BIT = 1;
	localparam int CMD_LEAP_OK_BIT = 2;
	localparam int DST_START_BIT = 0;
	localparam int DST_END_BIT = 1;
	localparam int STS_RED_BIT = 0;
	localparam int STS_GREEN_BIT = 1;
	localparam int STS_OC_BIT = 2;
	localparam int STS_RX_BIT = 3;
	localparam int STS_TX_BIT = 4;
	localparam int STS_LEAP_WAIT_BIT = 5;
	localparam int STS_BACKUP_BIT = 6;
	localparam int STS_POWER_BIT = 7;
	localparam int TIMERS_BYPASS_LSB = 16;

	// ----------------------------------------------------------------
	// Default values
	// ----------------------------------------------------------------
	localparam logic [15:0] DEF_UTC_OFS = 16'h0000;
	localparam logic [15:0] DEF_RESYNC_MIN = 16'h0000;
	localparam logic [15:0] DEF_BYPASS_MIN = 16'h0002;

	// Synchronisation states, best first: order is the rank
	typedef enum logic [2:0] {
		SSI_SYNCED_REGULATED,
		SSI_SYNCED_BYPASS_TIMER,
		SSI_SYNCED_SIMULATION,
		SSI_FREERUN_RESYNC_QUALIFYING,
		SSI_FREERUN_AFTER_SOURCE,
		SSI_FREERUN_AFTER_MANUAL_SET,
		SSI_TIME_NOT_VALID
	} ssi_sync_t;

	// All state of the block
	typedef struct packed {
		logic [2:0] rx_sync;
		logic rx_level;
		logic [2:0] pw_sync;
		logic pw_level;
		logic [31:0] flash_cnt;
		logic flash_ph;
		logic [31:0] rx_cnt;
		logic [31:0] tx_cnt;
		ssi_sync_t state;
		ssi_sync_t thresh;
		logic [15:0] utc_ofs;
		logic dst_start_en;
		logic dst_end_en;
		logic [15:0] resync_to;
		logic [15:0] bypass_to;
		logic leap_known;
		logic leap_wait;
		logic [31:0] time_s;
		logic [31:0] outage_s;
		logic valid_before;
		logic backup_used;
		logic d_wr;
		logic [7:0] d_addr;
		logic [31:0] hrdata;
		logic ready;
		logic resp;
		logic led_red;
		logic led_green;
		logic led_rx;
		logic led_tx;
		logic oc_on;
		logic restart;
		logic resync_hold;
	} ssi_state_t;

	localparam ssi_state_t SSI_ST_RESET = '{
		state: SSI_TIME_NOT_VALID,
		thresh: SSI_SYNCED_REGULATED,
		bypass_to: DEF_BYPASS_MIN,
		resync_to: DEF_RESYNC_MIN,
		utc_ofs: DEF_UTC_OFS,
		rx_sync: 3'h7,
		rx_level: 1'b1,
		// Power pin idles high; starting there avoids a false rise
		pw_sync: 3'h7,
		pw_level: 1'b1,
		ready: 1'b1,
		led_red: 1'b1,
		default: '0
	};

endpackage

// File: ssi_top.sv
// Status indication for a satellite-synchronised clock board: LED pair,
// isolated status output, link activity LEDs, back-up clock, defaults.
// Assumes one AHB-Lite master, an idle-high serial receive line and a
// transmitter on hclk that raises tx_busy while it sends.
//
// What this block does
// - synced and regulated: red off, green steady on.
// - synced with bypass timer running: red off, green flashing.
// - synced in simulation mode: red flashing, green steady on.
// - free-run while resync qualifying: red and green both flashing.
// - free-run after being set from source: red and green steady on.
// - free-run after manual set or reset: red on, green flashing.
// - no valid time: red on, green off; both dark never steady.
// - status output conducts when state equals or beats the threshold.
// - status output blocked when state ranks worse than threshold.
// - threshold is writable and used by the following comparisons.
// - receive LED lit while activity is seen on the receive line.
// - transmit LED lit while the block's transmitter is sending.
// - back-up clock keeps counting through an outage up to three days.
// - short outage restarts from back-up time unless valid before.
// - restart command pulses controller reset, settings untouched.
// - restore defaults discards stored leap second information.
// - restore defaults sets time offset to zero hours, zero minutes.
// - restore defaults disables both summer-time changeovers.
// - restore defaults sets qualify timeout 0, bypass timeout 2 minutes.
// - after defaults, resync is held until leap second data is known.
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
module ssi_top
	import ssi_pkg::*;
#(
	parameter int unsigned FLASH_HALF_CYC = FLASH_HALF_CYC_DEF,
	parameter int unsigned ACT_HOLD_CYC = ACT_HOLD_CYC_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd,
	input wire logic tx_busy,
	input wire logic power_ok,
	output logic led_red,
	output logic led_green,
	output logic led_rx,
	output logic led_tx,
	output logic status_oc,
	output logic ctrl_restart,
	output logic resync_hold
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Out-of-range codes fold onto the worst state
	function automatic ssi_sync_t to_sync(input logic [2:0] v);
		ssi_sync_t s;
		s = SSI_TIME_NOT_VALID;
		if (v <= 3'(SSI_TIME_NOT_VALID)) begin
			s = ssi_sync_t'(v);
		end
		return s;
	endfunction

	// Activity stretch counter: reload on event, else count down
	function automatic logic [31:0] stretch(input logic evt,
			input logic [31:0] cnt);
		logic [31:0] c;
		c = cnt;
		if (evt) begin
			c = 32'(ACT_HOLD_CYC);
		end else if (cnt != 32'h0) begin
			c = cnt - 32'h1;
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	ssi_state_t r;
	ssi_state_t n;
	logic rx_evt;
	logic pw_rise;
	logic pw_fall;
	logic sec_tick;
	logic acc;

	// Whole block in one process; bus writes are applied last so that
	// software wins over the housekeeping of the same cycle
	always_comb begin
		n = r;
		n.restart = 1'b0;
		n.resp = 1'b0;
		n.ready = 1'b1;

		// Three-stage synchronisers; only stages two and three are compared
		n.rx_sync = {r.rx_sync[1:0], rxd};
		n.pw_sync = {r.pw_sync[1:0], power_ok};
		rx_evt = (r.rx_sync[1] == r.rx_sync[2]) &&
			(r.rx_sync[2] != r.rx_level);
		pw_rise = (r.pw_sync[1] == r.pw_sync[2]) && r.pw_sync[2] &&
			!r.pw_level;
		pw_fall = (r.pw_sync[1] == r.pw_sync[2]) && !r.pw_sync[2] &&
			r.pw_level;
		if (r.rx_sync[1] == r.rx_sync[2]) begin
			n.rx_level = r.rx_sync[2];
		end
		if (r.pw_sync[1] == r.pw_sync[2]) begin
			n.pw_level = r.pw_sync[2];
		end

		// common flash base
		// One counter drives every flashing LED, so they stay in step
		sec_tick = 1'b0;
		if (r.flash_cnt == 32'(FLASH_HALF_CYC - 1)) begin
			n.flash_cnt = 32'h0;
			n.flash_ph = ~r.flash_ph;
			sec_tick = r.flash_ph;
		end else begin
			n.flash_cnt = r.flash_cnt + 32'h1;
		end

		n.rx_cnt = stretch(rx_evt, r.rx_cnt);
		n.tx_cnt = stretch(tx_busy, r.tx_cnt);
		n.led_rx = (r.rx_cnt != 32'h0);
		n.led_tx = (r.tx_cnt != 32'h0);

		// back-up seconds and outage length
		// Outage count saturates so a long outage never looks short
		if (sec_tick) begin
			n.time_s = r.time_s + 32'h1;
			if (!r.pw_level && r.outage_s < OUTAGE_MAX_S) begin
				n.outage_s = r.outage_s + 32'h1;
			end
		end
		if (pw_fall) begin
			n.valid_before = (r.state != SSI_TIME_NOT_VALID);
			n.outage_s = 32'h0;
			n.backup_used = 1'b0;
		end
		if (pw_rise) begin
			if (r.outage_s >= OUTAGE_MAX_S) begin
				n.time_s = 32'h0;
				n.state = SSI_TIME_NOT_VALID;
			end else if (!r.valid_before) begin
				n.backup_used = 1'b1;
			end
		end

		case (r.state)
			SSI_SYNCED_REGULATED: begin
				n.led_red = 1'b0;
				n.led_green = 1'b1;
			end
			SSI_SYNCED_BYPASS_TIMER: begin
				n.led_red = 1'b0;
				n.led_green = r.flash_ph;
			end
			SSI_SYNCED_SIMULATION: begin
				n.led_red = r.flash_ph;
				n.led_green = 1'b1;
			end
			SSI_FREERUN_RESYNC_QUALIFYING: begin
				n.led_red = r.flash_ph;
				n.led_green = ~r.flash_ph;
			end
			SSI_FREERUN_AFTER_SOURCE: begin
				n.led_red = 1'b1;
				n.led_green = 1'b1;
			end
			SSI_FREERUN_AFTER_MANUAL_SET: begin
				n.led_red = 1'b1;
				n.led_green = r.flash_ph;
			end
			default: begin
				n.led_red = 1'b1;
				n.led_green = 1'b0;
			end
		endcase

		// threshold compare by rank
		// Lower enum index ranks better, so less-or-equal means good enough
		n.oc_on = (r.state <= r.thresh);

		n.resync_hold = r.leap_wait;

		// Data phase of a write: hsize is not looked at, every write stores whole fields
		if (r.d_wr) begin
			case (r.d_addr)
				SSI_STATE_OFS: begin
					n.state = to_sync(hwdata[2:0]);
				end
				SSI_THRESH_OFS: begin
					n.thresh = to_sync(hwdata[2:0]);
				end
				SSI_CMD_OFS: begin
					n.restart = hwdata[CMD_RESTART_BIT];
					if (hwdata[CMD_LEAP_OK_BIT]) begin
						n.leap_known = 1'b1;
						n.leap_wait = 1'b0;
					end
					// Defaults win over a leap-known flag in the same write
					if (hwdata[CMD_DEFAULTS_BIT]) begin
						n.leap_known = 1'b0;
						n.leap_wait = 1'b1;
						n.utc_ofs = DEF_UTC_OFS;
						n.dst_start_en = 1'b0;
						n.dst_end_en = 1'b0;
						n.resync_to = DEF_RESYNC_MIN;
						n.bypass_to = DEF_BYPASS_MIN;
					end
				end
				SSI_UTC_OFS: begin
					n.utc_ofs = hwdata[15:0];
				end
				SSI_DST_OFS: begin
					n.dst_start_en = hwdata[DST_START_BIT];
					n.dst_end_en = hwdata[DST_END_BIT];
				end
				SSI_TIMERS_OFS: begin
					n.resync_to = hwdata[15:0];
					n.bypass_to = hwdata[TIMERS_BYPASS_LSB +: 16];
				end
				SSI_TIME_OFS: begin
					n.time_s = hwdata;
				end
				default: begin
				end
			endcase
		end

		// Address phase; read data is taken from the updated copy so a
		// read right behind a write returns the new value
		acc = hsel && hready && htrans[1];
		n.d_wr = acc && hwrite;
		n.d_addr = haddr[7:0];
		if (acc && !hwrite) begin
			n.hrdata = 32'h0;
			case (haddr[7:0])
				SSI_STATE_OFS: n.hrdata[2:0] = n.state;
				SSI_THRESH_OFS: n.hrdata[2:0] = n.thresh;
				SSI_STATUS_OFS: begin
					n.hrdata[STS_RED_BIT] = r.led_red;
					n.hrdata[STS_GREEN_BIT] = r.led_green;
					n.hrdata[STS_OC_BIT] = r.oc_on;
					n.hrdata[STS_RX_BIT] = r.led_rx;
					n.hrdata[STS_TX_BIT] = r.led_tx;
					n.hrdata[STS_LEAP_WAIT_BIT] = n.leap_wait;
					n.hrdata[STS_BACKUP_BIT] = n.backup_used;
					n.hrdata[STS_POWER_BIT] = r.pw_level;
				end
				SSI_UTC_OFS: n.hrdata[15:0] = n.utc_ofs;
				SSI_DST_OFS: begin
					n.hrdata[DST_START_BIT] = n.dst_start_en;
					n.hrdata[DST_END_BIT] = n.dst_end_en;
				end
				SSI_TIMERS_OFS: n.hrdata = {n.bypass_to, n.resync_to};
				SSI_TIME_OFS: n.hrdata = n.time_s;
				SSI_OUTAGE_OFS: n.hrdata = n.outage_s;
				default: n.hrdata = 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Clock enable freezes everything, bus answer included
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= SSI_ST_RESET;
		end else if (clk_en) begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign hreadyout = r.ready;
	assign hresp = r.resp;
	assign hrdata = r.hrdata;
	assign led_red = r.led_red;
	assign led_green = r.led_green;
	assign led_rx = r.led_rx;
	assign led_tx = r.led_tx;
	assign status_oc = r.oc_on;
	assign ctrl_restart = r.restart;
	assign resync_hold = r.resync_hold;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sync_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_SYNCED_REGULATED |->
			!led_red && led_green)
		else $error("synced regulated LEDs wrong");
	bypass_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_SYNCED_BYPASS_TIMER |->
			!led_red && led_green == $past(r.flash_ph))
		else $error("bypass timer LEDs wrong");
	sim_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_SYNCED_SIMULATION |->
			led_red == $past(r.flash_ph) && led_green)
		else $error("simulation LEDs wrong");
	qual_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_FREERUN_RESYNC_QUALIFYING |->
			led_red == $past(r.flash_ph) && led_green != led_red)
		else $error("qualifying LEDs wrong");
	source_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_FREERUN_AFTER_SOURCE |->
			led_red && led_green)
		else $error("free-run after source LEDs wrong");
	manual_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_FREERUN_AFTER_MANUAL_SET |->
			led_red && led_green == $past(r.flash_ph))
		else $error("manual set LEDs wrong");
	invalid_leds_a: assert property (
		$past(clk_en) && $past(r.state) == SSI_TIME_NOT_VALID |->
			led_red && !led_green)
		else $error("invalid time LEDs wrong");
	flash_rate_a: assert property (
		$past(clk_en) && r.flash_ph != $past(r.flash_ph) |->
			$past(r.flash_cnt) == 32'(FLASH_HALF_CYC - 1) && r.flash_cnt == 0)
		else $error("flash toggled off its period");
	oc_rank_a: assert property (
		$past(clk_en) |-> status_oc == ($past(r.state) <= $past(r.thresh)))
		else $error("status output disagrees with threshold");
	thresh_wr_a: assert property (
		$past(clk_en) && $past(r.d_wr) && $past(r.d_addr) == SSI_THRESH_OFS
			|-> r.thresh == to_sync($past(hwdata[2:0])))
		else $error("threshold write not applied");
	rx_led_a: assert property (
		(clk_en && rx_evt) ##1 clk_en |=> led_rx)
		else $error("receive LED not lit after activity");
	tx_led_a: assert property (
		(clk_en && tx_busy) ##1 clk_en |=> led_tx)
		else $error("transmit LED not lit while sending");
	outage_cap_a: assert property (
		r.outage_s <= OUTAGE_MAX_S)
		else $error("outage count beyond limit");
	backup_start_a: assert property (
		clk_en && pw_rise && r.outage_s < OUTAGE_MAX_S && !r.valid_before
			|=> r.backup_used)
		else $error("back-up time not used after short outage");
	restart_a: assert property (
		clk_en && r.d_wr && r.d_addr == SSI_CMD_OFS &&
			hwdata[CMD_RESTART_BIT] && !hwdata[CMD_DEFAULTS_BIT] |=>
			ctrl_restart && r.utc_ofs == $past(r.utc_ofs) &&
			r.bypass_to == $past(r.bypass_to))
		else $error("restart pulse missing or settings touched");
	defaults_a: assert property (
		clk_en && r.d_wr && r.d_addr == SSI_CMD_OFS &&
			hwdata[CMD_DEFAULTS_BIT] |=> !r.leap_known &&
			r.utc_ofs == DEF_UTC_OFS && !r.dst_start_en && !r.dst_end_en &&
			r.resync_to == DEF_RESYNC_MIN && r.bypass_to == DEF_BYPASS_MIN)
		else $error("defaults not restored");
	leap_hold_a: assert property (
		$past(clk_en) && $past(r.leap_wait) |-> resync_hold)
		else $error("resync not held while leap data missing");

	sync_seen_c: cover property (led_green && !led_red);
	defaults_seen_c: cover property (r.leap_wait ##1 !r.leap_wait);
	backup_seen_c: cover property (pw_rise && !r.valid_before);
	oc_drop_c: cover property (status_oc ##1 !status_oc);

endmodule

// File: ssi_pc_model.sv
// Stand-in for the configuration PC on the far end of the serial link.
// Assumes the bench strobes go for one hclk cycle per byte to send.
module ssi_pc_model #(
	parameter int BIT_CYC = 4
) (
	input wire logic hclk,
	input wire logic go,
	input wire logic [7:0] byte_in,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [9:0] frame;

	// ------------------------------------------------------------
	// Framing
	// ------------------------------------------------------------
	// writes reach the board as whole framed bytes
	// line idles high, start low, stop high
	initial rxd = 1'b1;
	always begin
		@(posedge hclk iff go);
		frame = {1'b1, byte_in, 1'b0};
		// LSB first, each bit held a fixed bit time
		for (int i = 0; i < 10; i++) begin
			rxd <= frame[i];
			repeat (BIT_CYC) @(posedge hclk);
		end
	end
endmodule

// File: sync_status_indicator_tb.sv
// Self-checking bench for the status indication block.
// Assumes zero-wait AHB-Lite slave and short flash and hold counts.
module sync_status_indicator_tb;
	import ssi_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int FH = 8;
	localparam int AH = 16;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp, led_red, led_green, led_rx, led_tx;
	logic status_oc, ctrl_restart, resync_hold, rxd;
	logic [31:0] hrdata;
	logic tx_busy = 1'b0;
	logic power_ok = 1'b1;
	logic go = 1'b0;
	logic clk_en = 1'b1;
	int fail_count = 0;
	int comparisons = 0;

	always #5 hclk = ~hclk;

	ssi_top #(.FLASH_HALF_CYC(FH), .ACT_HOLD_CYC(AH)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rxd(rxd), .tx_busy(tx_busy), .power_ok(power_ok),
		.led_red(led_red), .led_green(led_green), .led_rx(led_rx),
		.led_tx(led_tx), .status_oc(status_oc),
		.ctrl_restart(ctrl_restart), .resync_hold(resync_hold)
	);

	// Bit time well below the hold count, as on the real line
	ssi_pc_model #(.BIT_CYC(2)) u_pc (
		.hclk(hclk), .go(go), .byte_in(8'h5a), .rxd(rxd)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(logic [31:0] seen, logic [31:0] exp, string m);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	// Only the watchdog ends a wait that never ends
	task automatic wait_rdy();
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
	endtask

	// One single transfer; read data taken at the data-phase edge
	task automatic bus(logic [7:0] a, logic wr, logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk(hresp, 1'b0, "response not okay");
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
	endtask

	task automatic rd_chk(logic [7:0] a, logic [31:0] e, string m);
		logic [31:0] x;
		bus(a, 1'b0, '0, x);
		chk(x, e, m);
	endtask

	// Count lit cycles over one full flash period
	task automatic led_ones(output int r, output int g);
		r = 0;
		g = 0;
		repeat (4) @(posedge hclk);
		for (int i = 0; i < 2 * FH; i++) begin
			@(posedge hclk);
			#1;
			r += (led_red === 1'b1);
			g += (led_green === 1'b1);
		end
	endtask

	// Cycles from one rise of a flashing LED to the next
	task automatic flash_period(logic use_red, output int p);
		logic v, pv;
		int rises;
		p = 0;
		rises = 0;
		pv = 1'b1;
		while (rises < 2) begin
			@(posedge hclk);
			#1;
			v = use_red ? led_red : led_green;
			if (rises > 0) begin
				p++;
			end
			if (v === 1'b1 && pv === 1'b0) begin
				rises++;
			end
			pv = v;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd_chk(SSI_STATE_OFS, 32'h6, "state after reset");
		rd_chk(SSI_THRESH_OFS, 32'h0, "threshold after reset");
		rd_chk(SSI_TIMERS_OFS, 32'h0002_0000, "timers after reset");
		rd_chk(8'hfc, 32'h0, "unmapped read");
		chk(led_red, 1'b1, "invalid red");
		chk(led_green, 1'b0, "invalid green");
		$display("test reset done");
	endtask

	// Lit counts per state: 16 steady on, 8 flashing, 0 off
	task automatic t_leds();
		int r, g, p;
		int er[7] = '{0, 0, 8, 8, 16, 16, 16};
		int eg[7] = '{16, 8, 16, 8, 16, 8, 0};
		for (int s = 0; s < 7; s++) begin
			wr(SSI_STATE_OFS, 32'(s));
			led_ones(r, g);
			chk(32'(r), 32'(er[s]), "red pattern");
			chk(32'(g), 32'(eg[s]), "green pattern");
			chk(32'(r + g), 32'(er[s] + eg[s]), "common rate");
			if (er[s] == 8) begin
				flash_period(1'b1, p);
				chk(32'(p), 32'(2 * FH), "red flash period");
			end
			if (eg[s] == 8) begin
				flash_period(1'b0, p);
				chk(32'(p), 32'(2 * FH), "green flash period");
			end
		end
		$display("test leds done");
	endtask

	// Clock enable low must hold the red and green LEDs, flashing ones included
	task automatic t_freeze();
		logic [31:0] x;
		wr(SSI_STATE_OFS, 32'h3);
		@(posedge hclk);
		clk_en <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
		x = 32'({led_red, led_green});
		repeat (3 * FH) @(posedge hclk);
		#1;
		chk(32'({led_red, led_green}), x, "leds frozen");
		@(posedge hclk);
		clk_en <= 1'b1;
		$display("test freeze done");
	endtask

	task automatic t_thresh();
		for (int t = 0; t < 7; t += 3) begin
			wr(SSI_THRESH_OFS, 32'(t));
			rd_chk(SSI_THRESH_OFS, 32'(t), "threshold readback");
			for (int s = 0; s < 7; s++) begin
				wr(SSI_STATE_OFS, 32'(s));
				repeat (2) @(posedge hclk);
				#1;
				chk(status_oc, s <= t, "status output");
			end
		end
		$display("test threshold done");
	endtask

	task automatic t_activity();
		chk(led_rx, 1'b0, "rx idle");
		@(posedge hclk);
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		repeat (12) @(posedge hclk);
		#1;
		chk(led_rx, 1'b1, "rx during frame");
		repeat (50) @(posedge hclk);
		#1;
		chk(led_rx, 1'b0, "rx after frame");
		@(posedge hclk);
		tx_busy <= 1'b1;
		repeat (3) @(posedge hclk);
		#1;
		chk(led_tx, 1'b1, "tx while sending");
		@(posedge hclk);
		tx_busy <= 1'b0;
		repeat (AH + 6) @(posedge hclk);
		#1;
		chk(led_tx, 1'b0, "tx after sending");
		$display("test activity done");
	endtask

	task automatic t_restart();
		int n;
		n = 0;
		wr(SSI_TIMERS_OFS, 32'h0007_0003);
		wr(SSI_CMD_OFS, 32'h1);
		// The pulse stands from the write's data-phase edge for one cycle
		repeat (6) begin
			#1;
			n += (ctrl_restart === 1'b1);
			@(posedge hclk);
		end
		chk(32'(n), 32'h1, "restart pulse count");
		rd_chk(SSI_TIMERS_OFS, 32'h0007_0003, "timers kept");
		$display("test restart done");
	endtask

	task automatic t_defaults();
		wr(SSI_UTC_OFS, 32'h0000_0130);
		wr(SSI_DST_OFS, 32'h3);
		wr(SSI_CMD_OFS, 32'h6);
		repeat (2) @(posedge hclk);
		#1;
		chk(resync_hold, 1'b1, "hold after defaults");
		rd_chk(SSI_UTC_OFS, 32'h0, "utc offset default");
		rd_chk(SSI_DST_OFS, 32'h0, "dst default");
		rd_chk(SSI_TIMERS_OFS, 32'h0002_0000, "timer default");
		wr(SSI_CMD_OFS, 32'h4);
		repeat (2) @(posedge hclk);
		#1;
		chk(resync_hold, 1'b0, "hold released");
		$display("test defaults done");
	endtask

	task automatic outage();
		power_ok <= 1'b0;
		repeat (20) @(posedge hclk);
		power_ok <= 1'b1;
		repeat (10) @(posedge hclk);
	endtask

	task automatic t_power();
		logic [31:0] x;
		wr(SSI_STATE_OFS, 32'h4);
		outage();
		rd_chk(SSI_STATE_OFS, 32'h4, "valid state kept");
		bus(SSI_STATUS_OFS, 1'b0, '0, x);
		chk(x[STS_BACKUP_BIT], 1'b0, "no backup when valid");
		bus(SSI_OUTAGE_OFS, 1'b0, '0, x);
		chk(32'(x != 32'h0), 32'h1, "outage counted");
		wr(SSI_STATE_OFS, 32'h6);
		outage();
		bus(SSI_STATUS_OFS, 1'b0, '0, x);
		chk(x[STS_BACKUP_BIT], 1'b1, "backup used");
		$display("test power done");
	endtask

	// ------------------------------------------------------------
	// Verdict and main sequence
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog: the whole run needs well under 20k cycles
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_leds();
		t_freeze();
		t_thresh();
		t_activity();
		t_restart();
		t_defaults();
		t_power();
		wrap_up();
	end
endmodule
